// [src/egoc_calib.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Each phase's accumulated power is scaled by one plus its signed gain over 2^23.
// - The gain word spans a weight change of plus or minus 25600 percent, 2^-23 per LSB.
// - One gain word per phase scales its active, fund active, reactive and apparent powers.
// - In line-cycle mode energy is gathered over a programmed number of half line cycles.
// - Bits 4 to 6 of the line-cycle mode register pick the zero-crossing phases.
// - A fixed line-cycle result is exact to within one LSB, carrying the remainder.
// - The threshold is the 8-bit threshold register with 27 zero bits appended.
// - The threshold register resets to 3, giving a threshold of 18000000 hex.
// - A signed per-phase active offset is added to total active power before accumulating.
// - The fund active offset acts on fund active power as the total offset does on total.
// - Phases B and C have their own total and fund active offsets, local to the phase.
// - Each phase has a fund reactive offset correcting only that phase's reactive energy.
// - The host reaches energy and calibration registers over the parallel req_i register port.
module egoc_calib (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire egoc_pkg::egoc_req_t req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  input wire egoc_pkg::egoc_sample_t [2:0] sample_i,
  input wire logic [2:0] zero_cross_i,
  output logic cycle_done_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  localparam int ENERGY_WORDS = egoc_pkg::NUM_PHASES * egoc_pkg::NUM_KINDS;

  // Energy window decode, shared by the store address and the read select
  function automatic logic energy_hit(input logic [15:0] a);
    energy_hit = (a >= egoc_pkg::ENERGY_BASE)
                 && (a < egoc_pkg::ENERGY_BASE + 16'(ENERGY_WORDS));
  endfunction

  // Scaled sample: p + p*gain/2^23, signed 32-bit gain gives -25600%..+25600%
  function automatic logic signed [31:0] gain_apply(input logic signed [31:0] p,
                                                     input logic signed [31:0] g);
    logic signed [63:0] prod;
    prod = 64'(p) * 64'(g);
    gain_apply = p + 32'(prod >>> egoc_pkg::GAIN_FRAC_BITS);
  endfunction

  function automatic logic signed [31:0] corr(input logic signed [31:0] p,
                                              input logic signed [31:0] g,
                                              input logic signed [31:0] os);
    corr = gain_apply(p + os, g);
  endfunction

  // ----------------------------------------
  // Calibration registers
  // ----------------------------------------
  logic [31:0] gain_q [3];
  logic [31:0] act_os_q [3];
  logic [31:0] fact_os_q [3];
  logic [31:0] frea_os_q [3];
  logic [7:0] thr_q;
  logic [7:0] lcm_q;
  logic [15:0] half_cnt_cfg_q;
  logic [31:0] reg_rdata;
  logic reg_hit;

  // Gain words
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < egoc_pkg::NUM_PHASES; i++) begin
        gain_q[i] <= 32'h0;
      end
    end else if (req_i.wr) begin
      case (req_i.addr)
        egoc_pkg::PHASE_A_POWER_GAIN: gain_q[0] <= req_i.wdata;
        egoc_pkg::PHASE_B_POWER_GAIN: gain_q[1] <= req_i.wdata;
        egoc_pkg::PHASE_C_POWER_GAIN: gain_q[2] <= req_i.wdata;
        default: ;
      endcase
    end
  end

  // Offset words, each bound to one phase and one power kind
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < egoc_pkg::NUM_PHASES; i++) begin
        act_os_q[i] <= 32'h0;
        fact_os_q[i] <= 32'h0;
        frea_os_q[i] <= 32'h0;
      end
    end else if (req_i.wr) begin
      case (req_i.addr)
        egoc_pkg::PHASE_A_ACTIVE_OFFSET: act_os_q[0] <= req_i.wdata;
        egoc_pkg::PHASE_B_ACTIVE_OFFSET: act_os_q[1] <= req_i.wdata;
        egoc_pkg::PHASE_C_ACTIVE_OFFSET: act_os_q[2] <= req_i.wdata;
        egoc_pkg::PHASE_A_FUND_ACTIVE_OFFSET: fact_os_q[0] <= req_i.wdata;
        egoc_pkg::PHASE_B_FUND_ACTIVE_OFFSET: fact_os_q[1] <= req_i.wdata;
        egoc_pkg::PHASE_C_FUND_ACTIVE_OFFSET: fact_os_q[2] <= req_i.wdata;
        egoc_pkg::PHASE_A_FUND_REACTIVE_OFFSET: frea_os_q[0] <= req_i.wdata;
        egoc_pkg::PHASE_B_FUND_REACTIVE_OFFSET: frea_os_q[1] <= req_i.wdata;
        egoc_pkg::PHASE_C_FUND_REACTIVE_OFFSET: frea_os_q[2] <= req_i.wdata;
        default: ;
      endcase
    end
  end

  // Threshold and line-cycle setup
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_q <= egoc_pkg::THR_RESET;
      lcm_q <= 8'h0;
      half_cnt_cfg_q <= egoc_pkg::HALF_CYCLE_RESET;
    end else if (req_i.wr) begin
      case (req_i.addr)
        egoc_pkg::ENERGY_THRESHOLD_UPPER: thr_q <= req_i.wdata[7:0];
        egoc_pkg::LINE_CYCLE_MODE_REGISTER: lcm_q <= req_i.wdata[7:0];
        egoc_pkg::HALF_CYCLE_COUNT: half_cnt_cfg_q <= req_i.wdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Threshold
  // ----------------------------------------
  logic [34:0] threshold;
  assign threshold = {thr_q, {egoc_pkg::THR_PAD_BITS{1'b0}}};

  // ----------------------------------------
  // Line-cycle timing
  // ----------------------------------------
  logic line_mode;
  logic [2:0] zx_sel;
  logic zx_event;
  logic [15:0] half_left_q;
  logic period_end;
  assign line_mode = lcm_q[egoc_pkg::LCM_ACC_BIT];
  assign zx_sel = lcm_q[egoc_pkg::LCM_ZX_HI:egoc_pkg::LCM_ZX_LO];
  assign zx_event = |(zero_cross_i & zx_sel);
  assign period_end = line_mode && zx_event && (half_left_q <= 16'h0001);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      half_left_q <= egoc_pkg::HALF_CYCLE_RESET;
    end else if (!line_mode) begin
      half_left_q <= half_cnt_cfg_q;
    end else if (zx_event) begin
      // Count half cycles on the selected phases
      half_left_q <= period_end ? half_cnt_cfg_q : half_left_q - 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cycle_done_o <= 1'b0;
    end else begin
      cycle_done_o <= period_end;
    end
  end

  // ----------------------------------------
  // Corrected samples
  // ----------------------------------------
  logic signed [31:0] cal [3][4];
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      // One gain word for all four kinds
      cal[p][0] = corr(sample_i[p].active, gain_q[p], act_os_q[p]);
      cal[p][1] = corr(sample_i[p].fund_active, gain_q[p], fact_os_q[p]);
      cal[p][2] = corr(sample_i[p].reactive, gain_q[p], frea_os_q[p]);
      cal[p][3] = gain_apply(sample_i[p].apparent, gain_q[p]);
    end
  end

  // ----------------------------------------
  // Accumulation
  // ----------------------------------------
  // Residue below the threshold is kept, so quantisation stays within one LSB
  logic signed [47:0] acc_q [3][4];
  logic [31:0] count_q [3][4];
  logic [31:0] pend_q [3][4];
  logic signed [47:0] acc_n [3][4];
  logic signed [47:0] acc_d [3][4];
  logic cross_up [3][4];
  logic cross_dn [3][4];
  logic thr_live;
  logic [3:0] step_q;
  logic we;
  logic [3:0] waddr;
  logic [31:0] wdata;
  logic signed [47:0] thr_s;
  assign thr_s = 48'(threshold);
  // A zero threshold stops counting instead of counting every cycle
  assign thr_live = (thr_q != 8'h00);

  // One crossing per cycle; idle cycles drain a residue above the threshold,
  // so a sample worth several LSBs still lands in full
  always_comb begin
    for (int p = 0; p < egoc_pkg::NUM_PHASES; p++) begin
      for (int k = 0; k < egoc_pkg::NUM_KINDS; k++) begin
        acc_n[p][k] = acc_q[p][k];
        if (sample_i[p].valid) begin
          acc_n[p][k] = acc_q[p][k] + 48'(cal[p][k]);
        end
        cross_up[p][k] = thr_live && (acc_n[p][k] >= thr_s);
        cross_dn[p][k] = thr_live && !cross_up[p][k] && (acc_n[p][k] <= -thr_s);
        acc_d[p][k] = acc_n[p][k];
        if (cross_up[p][k]) begin
          acc_d[p][k] = acc_n[p][k] - thr_s;
        end else if (cross_dn[p][k]) begin
          acc_d[p][k] = acc_n[p][k] + thr_s;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < egoc_pkg::NUM_PHASES; p++) begin
        for (int k = 0; k < egoc_pkg::NUM_KINDS; k++) begin
          acc_q[p][k] <= 48'sh0;
        end
      end
    end else begin
      for (int p = 0; p < egoc_pkg::NUM_PHASES; p++) begin
        for (int k = 0; k < egoc_pkg::NUM_KINDS; k++) begin
          acc_q[p][k] <= acc_d[p][k];
        end
      end
    end
  end

  // A crossing on the closing cycle opens the next period, never lost
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < egoc_pkg::NUM_PHASES; p++) begin
        for (int k = 0; k < egoc_pkg::NUM_KINDS; k++) begin
          count_q[p][k] <= 32'h0;
        end
      end
    end else begin
      for (int p = 0; p < egoc_pkg::NUM_PHASES; p++) begin
        for (int k = 0; k < egoc_pkg::NUM_KINDS; k++) begin
          if (period_end) begin
            count_q[p][k] <= cross_up[p][k] ? 32'h1
                             : (cross_dn[p][k] ? 32'hffffffff : 32'h0);
          end else if (cross_up[p][k]) begin
            count_q[p][k] <= count_q[p][k] + 32'h1;
          end else if (cross_dn[p][k]) begin
            count_q[p][k] <= count_q[p][k] - 32'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < egoc_pkg::NUM_PHASES; p++) begin
        for (int k = 0; k < egoc_pkg::NUM_KINDS; k++) begin
          pend_q[p][k] <= 32'h0;
        end
      end
    end else begin
      for (int p = 0; p < egoc_pkg::NUM_PHASES; p++) begin
        for (int k = 0; k < egoc_pkg::NUM_KINDS; k++) begin
          // Snapshot at period end, running counts while line mode is off
          if (period_end || !line_mode) begin
            pend_q[p][k] <= count_q[p][k];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Energy store
  // ----------------------------------------
  // Copy snapshots into the readable store one word per cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      step_q <= 4'h0;
    end else begin
      step_q <= (step_q == 4'(ENERGY_WORDS - 1)) ? 4'h0 : step_q + 4'h1;
    end
  end
  assign we = 1'b1;
  assign waddr = step_q;
  assign wdata = pend_q[step_q[3:2]][step_q[1:0]];

  logic [31:0] mem_rdata;
  logic [3:0] raddr;
  assign raddr = energy_hit(req_i.addr) ? 4'(req_i.addr - egoc_pkg::ENERGY_BASE) : 4'h0;

  egoc_energy_mem u_mem (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .we_i(we),
    .waddr_i(waddr),
    .wdata_i(wdata),
    .raddr_i(raddr),
    .rdata_o(mem_rdata)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    reg_hit = 1'b1;
    reg_rdata = 32'h0;
    case (req_i.addr)
      egoc_pkg::PHASE_A_POWER_GAIN: reg_rdata = gain_q[0];
      egoc_pkg::PHASE_B_POWER_GAIN: reg_rdata = gain_q[1];
      egoc_pkg::PHASE_C_POWER_GAIN: reg_rdata = gain_q[2];
      egoc_pkg::PHASE_A_ACTIVE_OFFSET: reg_rdata = act_os_q[0];
      egoc_pkg::PHASE_B_ACTIVE_OFFSET: reg_rdata = act_os_q[1];
      egoc_pkg::PHASE_C_ACTIVE_OFFSET: reg_rdata = act_os_q[2];
      egoc_pkg::PHASE_A_FUND_ACTIVE_OFFSET: reg_rdata = fact_os_q[0];
      egoc_pkg::PHASE_B_FUND_ACTIVE_OFFSET: reg_rdata = fact_os_q[1];
      egoc_pkg::PHASE_C_FUND_ACTIVE_OFFSET: reg_rdata = fact_os_q[2];
      egoc_pkg::PHASE_A_FUND_REACTIVE_OFFSET: reg_rdata = frea_os_q[0];
      egoc_pkg::PHASE_B_FUND_REACTIVE_OFFSET: reg_rdata = frea_os_q[1];
      egoc_pkg::PHASE_C_FUND_REACTIVE_OFFSET: reg_rdata = frea_os_q[2];
      egoc_pkg::ENERGY_THRESHOLD_UPPER: reg_rdata = {24'h0, thr_q};
      egoc_pkg::LINE_CYCLE_MODE_REGISTER: reg_rdata = {24'h0, lcm_q};
      egoc_pkg::HALF_CYCLE_COUNT: reg_rdata = {16'h0, half_cnt_cfg_q};
      default: reg_hit = 1'b0;
    endcase
  end

  logic rd_q;
  logic rd_mem_q;
  logic [31:0] reg_rdata_q;
  // Answer strobe and source select
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= 1'b0;
      rd_mem_q <= 1'b0;
    end else begin
      rd_q <= req_i.rd;
      rd_mem_q <= req_i.rd && !reg_hit && energy_hit(req_i.addr);
    end
  end

  // Register words captured every cycle; only an answered cycle matters
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_q <= 32'h0;
    end else begin
      reg_rdata_q <= reg_rdata;
    end
  end
  assign rvalid_o = rd_q;
  assign rdata_o = rd_mem_q ? mem_rdata : reg_rdata_q;
endmodule
`default_nettype wire

// [include/egoc_pkg.sv]
package egoc_pkg;
  // ----------------------------------------
  // Register indices (word addresses)
  // ----------------------------------------
  localparam logic [15:0] PHASE_A_POWER_GAIN = 16'h4389;
  localparam logic [15:0] PHASE_A_ACTIVE_OFFSET = 16'h438a;
  localparam logic [15:0] PHASE_B_POWER_GAIN = 16'h438b;
  localparam logic [15:0] PHASE_B_ACTIVE_OFFSET = 16'h438c;
  localparam logic [15:0] PHASE_C_POWER_GAIN = 16'h438d;
  localparam logic [15:0] PHASE_C_ACTIVE_OFFSET = 16'h438e;
  localparam logic [15:0] PHASE_A_FUND_ACTIVE_OFFSET = 16'h43a2;
  localparam logic [15:0] PHASE_B_FUND_ACTIVE_OFFSET = 16'h43a3;
  localparam logic [15:0] PHASE_C_FUND_ACTIVE_OFFSET = 16'h43a4;
  localparam logic [15:0] PHASE_A_FUND_REACTIVE_OFFSET = 16'h43a5;
  localparam logic [15:0] PHASE_B_FUND_REACTIVE_OFFSET = 16'h43a6;
  localparam logic [15:0] PHASE_C_FUND_REACTIVE_OFFSET = 16'h43a7;
  localparam logic [15:0] ENERGY_THRESHOLD_UPPER = 16'h43b0;
  localparam logic [15:0] LINE_CYCLE_MODE_REGISTER = 16'h43b1;
  localparam logic [15:0] HALF_CYCLE_COUNT = 16'h43b2;
  localparam logic [15:0] ENERGY_BASE = 16'h43c0;
  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int GAIN_FRAC_BITS = 23;
  localparam int THR_PAD_BITS = 27;
  localparam int LCM_ACC_BIT = 0;
  localparam int LCM_ZX_LO = 4;
  localparam int LCM_ZX_HI = 6;
  localparam logic [7:0] THR_RESET = 8'h03;
  localparam logic [15:0] HALF_CYCLE_RESET = 16'h0064;
  localparam int NUM_PHASES = 3;
  localparam int NUM_KINDS = 4;
  localparam int ACC_W = 48;

  typedef enum logic [1:0] {
    EGOC_ACTIVE,
    EGOC_FUND_ACTIVE,
    EGOC_REACTIVE,
    EGOC_APPARENT
  } egoc_kind_t;

  typedef struct packed {
    logic valid;
    logic signed [31:0] active;
    logic signed [31:0] fund_active;
    logic signed [31:0] reactive;
    logic signed [31:0] apparent;
  } egoc_sample_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } egoc_req_t;
endpackage

// [src/egoc_energy_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// Energy register store, one word per phase and power kind
module egoc_energy_mem (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem_q [16];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= 32'h0;
      end
    end else if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Registered read keeps bus data off the adder path
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule
`default_nettype wire

// [dv/egoc_meter_src.sv]
`timescale 1ns/1ps
`default_nettype none
module egoc_meter_src (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [7:0] count_i,
  input wire egoc_pkg::egoc_sample_t [2:0] value_i,
  output var egoc_pkg::egoc_sample_t [2:0] sample_o
);
  // ------------
  // Sample burst
  // ------------
  logic [7:0] left_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      left_q <= 8'h00;
    end else if (load_i) begin
      left_q <= count_i;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // Idle data inverted so stale words never pass
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      sample_o[p] = (left_q != 8'h00) ? value_i[p] : ~value_i[p];
      sample_o[p].valid = (left_q != 8'h00) && value_i[p].valid;
    end
  end
endmodule
`default_nettype wire

// [dv/egoc_calib_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module egoc_calib_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire egoc_pkg::egoc_req_t req_i,
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [2:0] zero_cross_i,
  input wire logic cycle_done_o
);
  // -------
  // Shadows
  // -------
  logic [7:0] thr_q, mode_q;
  logic [15:0] half_q, hits_q, a;
  logic last_q, hit, wrap;
  assign a = req_i.addr;
  assign hit = mode_q[0] && (|(zero_cross_i & mode_q[6:4]));
  assign wrap = hits_q + 16'h0001 == half_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_q <= 8'h03;
      mode_q <= 8'h00;
      half_q <= 16'h0064;
    end else if (req_i.wr) begin
      if (a == 16'h43b0) thr_q <= req_i.wdata[7:0];
      if (a == 16'h43b1) mode_q <= req_i.wdata[7:0];
      if (a == 16'h43b2) half_q <= req_i.wdata[15:0];
    end
  end
  // Several selected crossings in one cycle count once
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hits_q <= 16'h0000;
      last_q <= 1'b0;
    end else begin
      last_q <= hit && wrap;
      if (!mode_q[0]) hits_q <= 16'h0000;
      else if (hit) hits_q <= wrap ? 16'h0000 : hits_q + 16'h0001;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence cal_wr;
    req_i.wr && !req_i.rd && (a inside {[16'h4389:16'h438e], [16'h43a2:16'h43a7]});
  endsequence
  sequence same_rd;
    req_i.rd && !req_i.wr && a == $past(a);
  endsequence
  chk_rd_answer: assert property (req_i.rd |=> rvalid_o)
    else $error("read not answered");
  chk_rvalid_cause: assert property (rvalid_o |-> $past(req_i.rd))
    else $error("spurious answer");
  chk_unmapped_zero: assert property (req_i.rd && a < 16'h4389 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_thr_value: assert property (
    req_i.rd && !req_i.wr && a == 16'h43b0 |=> rdata_o == {24'h0, thr_q})
    else $error("bad threshold read");
  chk_half_value: assert property (
    req_i.rd && !req_i.wr && a == 16'h43b2 |=> rdata_o == {16'h0, half_q})
    else $error("bad half cycle read");
  chk_cal_readback: assert property (
    cal_wr ##1 same_rd |=> rdata_o == $past(req_i.wdata, 2))
    else $error("bad calibration read");
  chk_done_on_last: assert property (last_q |-> cycle_done_o)
    else $error("period end missed");
  chk_done_cause: assert property (cycle_done_o |-> last_q)
    else $error("early period end");
endmodule
bind egoc_calib egoc_calib_chk chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .zero_cross_i(zero_cross_i),
  .cycle_done_o(cycle_done_o));
`default_nettype wire

// [dv/egoc_calib_test.sv]
`timescale 1ns/1ps
`default_nettype none
module egoc_calib_test;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic load_q = 1'b0;
  logic [7:0] count_q = 8'h00;
  logic [2:0] zero_cross_i = 3'h0;
  egoc_pkg::egoc_req_t req_i = '0;
  egoc_pkg::egoc_sample_t [2:0] value_q = '0;
  egoc_pkg::egoc_sample_t [2:0] sample_i;
  logic [31:0] rdata_o;
  logic rvalid_o, cycle_done_o;
  int mismatches = 0;
  int samples_checked = 0;
  always #5 mclk_i = ~mclk_i;
  egoc_calib dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .sample_i(sample_i), .zero_cross_i(zero_cross_i),
    .cycle_done_o(cycle_done_o));
  egoc_meter_src src_u (.mclk_i(mclk_i), .rst_i(rst_i), .load_i(load_q), .count_i(count_q),
    .value_i(value_q), .sample_o(sample_i));
  // -----
  // Tasks
  // -----
  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Write leaves its strobe up so a read may follow at once
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    req_i <= '{1'b1, 1'b0, a, d};
    tick(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    req_i <= '{1'b0, 1'b1, a, 32'h0};
    tick(1);
    req_i <= '0;
    cmp(32'h1, {31'h0, rvalid_o});
    cmp(e, rdata_o);
    tick(1);
  endtask
  // Energy store refreshes slowly, hence the long settle
  task automatic feed(input int n, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] c);
    req_i <= '0;
    load_q <= 1'b1;
    count_q <= 8'(n);
    value_q <= '{'{1'b1, c, c, c, c}, '{1'b1, b, b, b, b}, '{1'b1, a, a, a, a}};
    tick(1);
    load_q <= 1'b0;
    tick(n + 22);
  endtask
  task automatic energy(input logic [31:0] e [12]);
    for (int i = 0; i < 12; i++) begin
      rd(16'h43c0 + 16'(i), e[i]);
    end
  endtask
  task automatic zc(input logic [2:0] m);
    zero_cross_i <= m;
    tick(1);
    zero_cross_i <= 3'h0;
  endtask
  task automatic reset_dut(input int n);
    rst_i <= 1'b1;
    tick(n);
    rst_i <= 1'b0;
  endtask
  initial begin
    logic [15:0] a;
    logic seen;
    reset_dut(10);
    for (int i = 0; i < 12; i++) begin
      a = (i < 6) ? 16'h4389 + 16'(i) : 16'h439c + 16'(i);
      rd(a, 32'h0);
      wr(a, {16'(i) ^ 16'hc3a5, a});
      rd(a, {16'(i) ^ 16'hc3a5, a});
    end
    rd(16'h43b0, 32'h3);
    rd(16'h43b1, 32'h0);
    rd(16'h43b2, 32'h64);
    rd(16'h4000, 32'h0);
    reset_dut(2);
    wr(16'h438b, 32'h00400000);
    wr(16'h438d, 32'hffc00000);
    feed(4, 32'h0c000000, 32'h10000000, 32'h30000000);
    energy('{2, 2, 2, 2, 4, 4, 4, 4, 4, 4, 4, 4});
    reset_dut(2);
    wr(16'h43b0, 32'h1);
    wr(16'h438c, 32'h08000000);
    wr(16'h43a3, 32'h08000000);
    wr(16'h43a7, 32'h08000000);
    wr(16'h43a5, 32'hf8000000);
    rd(16'h43b0, 32'h1);
    feed(3, 32'h08000000, 32'h08000000, 32'h08000000);
    energy('{3, 3, 0, 3, 6, 6, 3, 3, 3, 3, 6, 3});
    reset_dut(2);
    wr(16'h43b2, 32'h2);
    wr(16'h43b1, 32'h21);
    feed(3, 32'h18000000, 32'h18000000, 32'h18000000);
    zc(3'b001);
    tick(1);
    zc(3'b010);
    tick(1);
    zc(3'b110);
    seen = 1'b0;
    for (int i = 0; i < 4 && !seen; i++) begin
      seen = cycle_done_o;
      if (!seen) tick(1);
    end
    cmp(32'h1, {31'h0, seen});
    if (seen === 1'b1) begin
      feed(2, 32'h18000000, 32'h18000000, 32'h18000000);
      energy('{3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3});
    end
    end_sim();
  end
  initial begin
    #500000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
